// File: rtl/aspir_pkg.sv
// Shared constants and types of the serial port; its infrared mode bit is stored only
package aspir_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_MODE   = 16'hFFA0;
    localparam logic [15:0] ADDR_STATUS = 16'hFFA1;
    localparam logic [15:0] ADDR_BAUD   = 16'hFFA2;
    localparam logic [15:0] ADDR_DATA   = 16'hFFA3;
    // Reset values
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET   = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'hFF;
    // Mode register field positions
    localparam int TX_EN_BIT   = 7;
    localparam int RX_EN_BIT   = 6;
    localparam int PAR_HI_BIT  = 5;
    localparam int PAR_LO_BIT  = 4;
    localparam int CLEN_BIT    = 3;
    localparam int STOP_BIT    = 2;
    localparam int ERRSUP_BIT  = 1;
    localparam int IRDA_BIT    = 0;
    // Status register field positions
    localparam int PERR_BIT    = 2;
    localparam int FERR_BIT    = 1;
    localparam int OVR_BIT     = 0;
    // Parity encodings
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    // Baud generator: base divisor and oversampling
    localparam logic [4:0] DIV_BASE    = 5'h10;
    localparam logic [3:0] DIV_FORBID  = 4'hF;
    localparam logic [3:0] OVS_LAST    = 4'hF;
    localparam logic [3:0] OVS_MID     = 4'h7;
    localparam logic [2:0] PRE_EXT     = 3'h0;

    // Decoded mode register
    typedef struct packed {
        logic       tx_en;
        logic       rx_en;
        logic [1:0] parity;
        logic       char8;
        logic       stop2;
        logic       err_sup;
        logic       irda;
    } aspir_mode_t;

    // Result of one received frame
    typedef struct packed {
        logic [7:0] data;
        logic       par_err;
        logic       frm_err;
    } aspir_rx_t;
endpackage : aspir_pkg

// File: rtl/aspir_baud.sv
// Baud generator: prescaler select and 5-bit divider, 16x tick out
`timescale 1ns/1ps
module aspir_baud (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] ctrl,
    input  wire logic       ext_clk,
    output logic            tick
);
    logic [6:0] pre_cnt;
    logic       ext_d;
    logic       src_pulse;
    logic [4:0] div_cnt;
    logic [4:0] div_last;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pre_cnt <= 7'h00;
        else
            pre_cnt <= pre_cnt + 7'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ext_d <= 1'b0;
        else
            ext_d <= ext_clk;
    end

    always_comb
    begin
        if (ctrl[6:4] == aspir_pkg::PRE_EXT)
            src_pulse = ext_clk & ~ext_d;
        else
            src_pulse = (pre_cnt & ((7'h01 << ctrl[6:4]) - 7'h01))
                        == ((7'h01 << ctrl[6:4]) - 7'h01);
    end

    assign div_last = aspir_pkg::DIV_BASE + {1'b0, ctrl[3:0]} - 5'h01;

    // n=2, k=4 at 40 MHz gives the MIDI rate
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            div_cnt <= 5'h00;
        else if (ctrl[3:0] == aspir_pkg::DIV_FORBID)
            div_cnt <= 5'h00;
        else if (src_pulse)
            div_cnt <= (div_cnt >= div_last) ? 5'h00 : div_cnt + 5'h01;
    end

    // One tick per divided period, used as 16x oversample strobe
    assign tick = src_pulse && (div_cnt >= div_last)
                  && (ctrl[3:0] != aspir_pkg::DIV_FORBID);
endmodule : aspir_baud

// File: rtl/aspir_rx.sv
// Receive shifter: start detect, mid-bit sampling, error checks
`timescale 1ns/1ps
module aspir_rx (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 enable,
    input  wire logic                 tick,
    input  wire logic                 rxd,
    input  aspir_pkg::aspir_mode_t    mode,
    output logic                      done,
    output aspir_pkg::aspir_rx_t      result
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP}
        aspir_rxst_t;
    aspir_rxst_t state;
    logic [3:0]  ovs;
    logic [3:0]  nbit;
    logic [3:0]  nlast;
    logic [8:0]  receive_shift_reg;
    logic        rxd_d;
    logic        has_par;
    logic        par_calc;

    assign has_par = mode.parity[1];
    assign nlast   = (mode.char8 ? 4'h8 : 4'h7) + {3'h0, has_par};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rxd_d <= 1'b1;
        else
            rxd_d <= rxd;
    end

    // Bit 0 is still clear with 7 bits, so one sum fits both
    always_comb
    begin
        par_calc = ^receive_shift_reg[7:0];
        if (mode.parity == aspir_pkg::PAR_ODD)
            par_calc = ~par_calc;
    end

    // start on falling edge, sample at mid-bit
    always_ff @(posedge clk)
    begin
        if (!rst_n || !enable)
        begin
            state             <= RX_IDLE;
            ovs               <= 4'h0;
            nbit              <= 4'h0;
            receive_shift_reg <= 9'h000;
            done              <= 1'b0;
            result            <= '0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                RX_IDLE:
                    if (rxd_d && !rxd)
                    begin
                        state <= RX_START;
                        ovs   <= 4'h0;
                    end
                RX_START:
                    if (tick)
                    begin
                        if (ovs == aspir_pkg::OVS_MID)
                        begin
                            ovs  <= 4'h0;
                            nbit <= 4'h0;
                            // False start: line back at mark
                            state <= rxd ? RX_IDLE : RX_BITS;
                            receive_shift_reg <= 9'h000;
                        end
                        else
                            ovs <= ovs + 4'h1;
                    end
                RX_BITS:
                    if (tick)
                    begin
                        ovs <= ovs + 4'h1;
                        if (ovs == aspir_pkg::OVS_LAST)
                        begin
                            // LSB first, shift in from the top
                            receive_shift_reg <=
                                {rxd, receive_shift_reg[8:1]};
                            nbit <= nbit + 4'h1;
                            if (nbit + 4'h1 == nlast)
                                state <= RX_STOP;
                        end
                    end
                RX_STOP:
                    if (tick)
                    begin
                        ovs <= ovs + 4'h1;
                        if (ovs == aspir_pkg::OVS_LAST)
                        begin
                            state <= RX_IDLE;
                            done  <= 1'b1;
                            result.frm_err <= !rxd;
                            result.data <= '0;
                            result.par_err <= 1'b0;
                            // Align frame data to bit 0
                            case (nlast)
                                4'h7: result.data <=
                                    {1'b0, receive_shift_reg[8:2]};
                                4'h8: result.data <= receive_shift_reg[8:1];
                                4'h9:
                                begin
                                    result.data <= receive_shift_reg[7:0];
                                    result.par_err <=
                                        par_calc != receive_shift_reg[8];
                                end
                                default: result.data <= receive_shift_reg[7:0];
                            endcase
                            // 7-bit with parity: MSB reads 0
                            if (nlast == 4'h8 && has_par)
                            begin
                                result.data <=
                                    {1'b0, receive_shift_reg[7:1]};
                                result.par_err <=
                                    par_calc != receive_shift_reg[8];
                            end
                        end
                    end
                default: state <= RX_IDLE;
            endcase
        end
    end
endmodule : aspir_rx

// File: rtl/aspir_top.sv
// Asynchronous serial port top: registers, transmitter, pin muxing
`timescale 1ns/1ps

module aspir_top (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [15:0] ADDR,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        BIT_WR,
    input  wire logic [2:0]  BIT_SEL,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SERIAL_OUT_PIN,
    output logic             SERIAL_OUT_EN,
    input  wire logic        PORT_PIN_TX,
    input  wire logic        EXTERNAL_BAUD_CLOCK_PIN,
    output logic             RX_DONE_IRQ,
    output logic             TX_DONE_IRQ
);
    // Bit timing lives in the counters
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} aspir_txst_t;

    logic [7:0]             serial_mode_reg;
    logic [7:0]             baud_divider_control;
    logic [7:0]             receive_buffer_reg;
    logic [7:0]             transmit_shift_reg;
    logic [2:0]             serial_error_status_reg;
    logic                   buf_unread;
    aspir_pkg::aspir_mode_t mode;
    aspir_pkg::aspir_rx_t   rx_res;
    logic                   rx_done;
    logic                   tick;
    logic                   tx_go;
    logic                   data_sel;
    aspir_txst_t            tx_state;
    logic [11:0]            tx_frame;
    logic [3:0]             tx_left;
    logic [3:0]             tx_ovs;
    logic                   tx_line;
    logic [3:0]             tx_len;
    logic                   par_bit;

    // Struct view of the mode fields
    assign mode     = serial_mode_reg;
    assign data_sel = (ADDR == aspir_pkg::ADDR_DATA);
    // A busy write is dropped, not queued:
    // nothing holds a second byte
    // software never writes while busy; ignored if it does
    assign tx_go    = WR && data_sel && mode.tx_en && (tx_state == TX_IDLE);

    // Byte write beats bit write
    // bit and byte writes, reset zero
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            serial_mode_reg <= aspir_pkg::MODE_RESET;
        else if (ADDR == aspir_pkg::ADDR_MODE && WR)
            serial_mode_reg <= WDATA;
        else if (ADDR == aspir_pkg::ADDR_MODE && BIT_WR)
            serial_mode_reg[BIT_SEL] <= WDATA[0];
    end

    // Divider changes mid-frame upset timing;
    // software keeps it still in transfers
    // baud control register
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            baud_divider_control <= aspir_pkg::BAUD_RESET;
        else if (ADDR == aspir_pkg::ADDR_BAUD && WR)
            baud_divider_control <= WDATA;
    end

    // infrared value is up to software
    aspir_baud u_baud (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .ctrl    (baud_divider_control),
        .ext_clk (EXTERNAL_BAUD_CLOCK_PIN),
        .tick    (tick)
    );

    // Receive disable resets the receiver
    // receive shifter lives inside, no address
    aspir_rx u_rx (
        .clk    (CLOCK),
        .rst_n  (RST_N),
        .enable (mode.rx_en),
        .tick   (tick),
        .rxd    (SERIAL_IN_PIN),
        .mode   (mode),
        .done   (rx_done),
        .result (rx_res)
    );

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            receive_buffer_reg <= aspir_pkg::DATA_RESET;
        else if (rx_done)
            receive_buffer_reg <= rx_res.data;
    end

    // New character beats a read in one cycle,
    // so no overrun is lost
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            buf_unread <= 1'b0;
        else if (rx_done)
            buf_unread <= 1'b1;
        else if (RD && data_sel)
            buf_unread <= 1'b0;
    end

    // Flags hold the last frame only
    // error flags, refreshed per frame
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            serial_error_status_reg <= aspir_pkg::STATUS_RESET[2:0];
        else if (rx_done)
        begin
            serial_error_status_reg[aspir_pkg::PERR_BIT] <= rx_res.par_err;
            serial_error_status_reg[aspir_pkg::FERR_BIT] <= rx_res.frm_err;
            serial_error_status_reg[aspir_pkg::OVR_BIT]  <= buf_unread;
        end
    end

    // Read data held until the next read;
    // unmapped addresses read zero
    // shared address read side; status read-only
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            RDATA <= 8'h00;
        else if (RD)
        begin
            case (ADDR)
                aspir_pkg::ADDR_MODE:   RDATA <= serial_mode_reg;
                aspir_pkg::ADDR_STATUS:
                    RDATA <= {5'h00, serial_error_status_reg};
                aspir_pkg::ADDR_BAUD:   RDATA <= baud_divider_control;
                aspir_pkg::ADDR_DATA:   RDATA <= receive_buffer_reg;
                default:                RDATA <= 8'h00;
            endcase
        end
    end

    // Any error kind suppresses the request
    // receive completion request
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            RX_DONE_IRQ <= 1'b0;
        else
            RX_DONE_IRQ <= rx_done && !(mode.err_sup &&
                           (rx_res.par_err || rx_res.frm_err || buf_unread));
    end

    // Parity from the write data, so the frame
    // is whole in the cycle the byte is taken
    // parity bit value
    always_comb
    begin
        case (mode.parity)
            aspir_pkg::PAR_ODD:  par_bit = ~^(mode.char8 ? WDATA
                                          : {1'b0, WDATA[6:0]});
            aspir_pkg::PAR_EVEN: par_bit = ^(mode.char8 ? WDATA
                                         : {1'b0, WDATA[6:0]});
            default:             par_bit = 1'b0;
        endcase
    end

    // Frame bit count, loaded into tx_left
    // frame length: start+data+parity+stops
    always_comb
    begin
        tx_len = (mode.char8 ? 4'h9 : 4'h8)
                 + {3'h0, mode.parity != aspir_pkg::PAR_NONE}
                 + (mode.stop2 ? 4'h2 : 4'h1);
    end

    // Last byte taken; no read path
    // transmit register, written only
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            transmit_shift_reg <= aspir_pkg::DATA_RESET;
        else if (tx_go)
            transmit_shift_reg <= WDATA;
    end

    // Start bit goes out at once; ticks run free,
    // so it may be up to one tick short.
    // Enable low abandons a frame, line idles.
    // transmit sequencer
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || !mode.tx_en)
        begin
            tx_state <= TX_IDLE;
            tx_frame <= 12'hFFF;
            tx_left  <= 4'h0;
            tx_ovs   <= 4'h0;
            tx_line  <= 1'b1;
        end
        else
        begin
            case (tx_state)
                TX_IDLE:
                    if (tx_go)
                    begin
                        tx_state <= TX_SHIFT;
                        tx_ovs   <= 4'h0;
                        tx_left  <= tx_len;
                        tx_line  <= 1'b0;
                        if (mode.char8)
                            tx_frame <= (mode.parity == aspir_pkg::PAR_NONE)
                                ? {3'h7, WDATA, 1'b0}
                                : {2'h3, par_bit, WDATA, 1'b0};
                        else
                            tx_frame <= (mode.parity == aspir_pkg::PAR_NONE)
                                ? {4'hF, WDATA[6:0], 1'b0}
                                : {3'h7, par_bit, WDATA[6:0], 1'b0};
                    end
                TX_SHIFT:
                    if (tick)
                    begin
                        tx_ovs <= tx_ovs + 4'h1;
                        if (tx_ovs == aspir_pkg::OVS_LAST)
                        begin
                            tx_frame <= {1'b1, tx_frame[11:1]};
                            tx_line  <= tx_frame[1];
                            tx_left  <= tx_left - 4'h1;
                            if (tx_left == 4'h1)
                            begin
                                tx_state <= TX_IDLE;
                                tx_line  <= 1'b1;
                            end
                        end
                    end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Set with the tick ending the last stop bit
    // transmit completion after last stop bit
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            TX_DONE_IRQ <= 1'b0;
        else
            TX_DONE_IRQ <= (tx_state == TX_SHIFT) && tick
                           && tx_ovs == aspir_pkg::OVS_LAST
                           && tx_left == 4'h1;
    end

    // Transmitter off: pin follows the port latch
    // pin function; infrared flag stored only
    always_comb
    begin
        SERIAL_OUT_EN  = mode.tx_en;
        SERIAL_OUT_PIN = mode.tx_en ? tx_line : PORT_PIN_TX;
    end
endmodule : aspir_top

// File: testbench/aspir_monitor.sv
// Checker of the serial port pin, request and read timing
`timescale 1ns/1ps
module aspir_monitor (
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic [15:0] ADDR,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        SERIAL_OUT_PIN,
    input wire logic        SERIAL_OUT_EN,
    input wire logic        PORT_PIN_TX,
    input wire logic        RX_DONE_IRQ,
    input wire logic        TX_DONE_IRQ
);
    logic busy;
    logic take;

    assign take = WR && ADDR == aspir_pkg::ADDR_DATA && SERIAL_OUT_EN && !busy;

    // Frame in flight as seen from the pins; a refused write never sets it
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || TX_DONE_IRQ || !SERIAL_OUT_EN)
            busy <= 1'b0;
        else if (take)
            busy <= 1'b1;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    property p_port;
        !SERIAL_OUT_EN && !$past(SERIAL_OUT_EN) && $stable(PORT_PIN_TX)
            |-> SERIAL_OUT_PIN == PORT_PIN_TX;
    endproperty
    property p_start;
        take |=> !SERIAL_OUT_PIN [*8];
    endproperty
    property p_idle;
        SERIAL_OUT_EN && $past(SERIAL_OUT_EN) && !busy |-> SERIAL_OUT_PIN;
    endproperty
    property p_done_high;
        TX_DONE_IRQ |-> SERIAL_OUT_PIN && busy;
    endproperty
    property p_tx_pulse;
        TX_DONE_IRQ |=> !TX_DONE_IRQ;
    endproperty
    property p_rx_pulse;
        RX_DONE_IRQ |=> !RX_DONE_IRQ;
    endproperty
    property p_stop;
        !SERIAL_OUT_EN && !busy |-> !TX_DONE_IRQ;
    endproperty
    property p_rdata;
        !RD |=> $stable(RDATA);
    endproperty
    property p_no_restart;
        busy && WR && ADDR == aspir_pkg::ADDR_DATA |=> busy;
    endproperty

    a_port: assert property (p_port) else $error("port level not passed");
    a_start: assert property (p_start) else $error("start bit missing");
    a_idle: assert property (p_idle) else $error("line not idle high");
    a_done_high: assert property (p_done_high) else $error("bad done");
    a_tx_pulse: assert property (p_tx_pulse) else $error("long tx pulse");
    a_rx_pulse: assert property (p_rx_pulse) else $error("long rx pulse");
    a_stop: assert property (p_stop) else $error("transfer in stop");
    a_rdata: assert property (p_rdata) else $error("read data moved");
    a_no_restart: assert property (p_no_restart) else $error("busy lost");

    c_take: cover property (take);
    c_rx: cover property (RX_DONE_IRQ);
    c_tx: cover property (TX_DONE_IRQ);
    c_read: cover property (RD && ADDR == aspir_pkg::ADDR_STATUS);
endmodule : aspir_monitor

bind aspir_top aspir_monitor aspir_monitor_i (
    .CLOCK          (CLOCK),
    .RST_N          (RST_N),
    .ADDR           (ADDR),
    .WR             (WR),
    .RD             (RD),
    .RDATA          (RDATA),
    .SERIAL_OUT_PIN (SERIAL_OUT_PIN),
    .SERIAL_OUT_EN  (SERIAL_OUT_EN),
    .PORT_PIN_TX    (PORT_PIN_TX),
    .RX_DONE_IRQ    (RX_DONE_IRQ),
    .TX_DONE_IRQ    (TX_DONE_IRQ)
);

// File: testbench/aspir_remote.sv
// Remote serial device: sends given frames, samples frames at mid-bit
`timescale 1ns/1ps
module aspir_remote #(
    parameter int BIT = 512
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;

    task automatic send(input logic [11:0] f);
        for (int i = 0; i < 12; i++)
        begin
            line_out <= f[i];
            repeat (BIT) @(posedge clk);
        end
        line_out <= 1'b1;
        @(posedge clk);
    endtask : send

    task automatic recv(output logic [11:0] f);
        while (line_in !== 1'b0)
            @(posedge clk);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 12; i++)
        begin
            f[i] = line_in;
            repeat (BIT) @(posedge clk);
        end
    endtask : recv
endmodule : aspir_remote

// File: testbench/tb.sv
// Self-checking bench of the serial port; the infrared mode bit is never set
`timescale 1ns/1ps
module tb;
    localparam int BIT = 512;
    localparam logic [7:0] DAT [4] = '{8'hB1, 8'hCE, 8'h6D, 8'hF2};
    logic        clock;
    logic        rst_n;
    logic [15:0] addr;
    logic        we;
    logic        re;
    logic        bit_wr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rxd;
    logic        txd;
    logic        out_en;
    logic        port_tx;
    logic        ext_clk;
    logic        rx_irq;
    logic        tx_irq;
    logic [7:0]  rv;
    logic [7:0]  m;
    logic [11:0] fr;
    logic [11:0] fx;
    int          fails;
    int          compares;
    int          cyc;
    int          rx_n;
    int          tx_n;
    int          done_at;
    int          t0;

    aspir_top aspir_top_i (
        .CLOCK                   (clock),
        .RST_N                   (rst_n),
        .ADDR                    (addr),
        .WR                      (we),
        .RD                      (re),
        .BIT_WR                  (bit_wr),
        .BIT_SEL                 (bit_sel),
        .WDATA                   (wdata),
        .RDATA                   (rdata),
        .SERIAL_IN_PIN           (rxd),
        .SERIAL_OUT_PIN          (txd),
        .SERIAL_OUT_EN           (out_en),
        .PORT_PIN_TX             (port_tx),
        .EXTERNAL_BAUD_CLOCK_PIN (ext_clk),
        .RX_DONE_IRQ             (rx_irq),
        .TX_DONE_IRQ             (tx_irq)
    );
    aspir_remote #(.BIT(BIT)) aspir_remote_i (
        .clk      (clock),
        .line_in  (txd),
        .line_out (rxd)
    );

    always #12.5 clock = ~clock;

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        ext_clk <= ~ext_clk;
        if (rx_irq === 1'b1)
            rx_n <= rx_n + 1;
        if (tx_irq === 1'b1)
            tx_n <= tx_n + 1;
        if (tx_irq === 1'b1)
            done_at <= cyc;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
    endtask : put

    task automatic get(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        #1;
        v = rdata;
    endtask : get

    task automatic wait_cnt(ref int c, input int n);
        for (int k = 0; k < 3000 && c < n; k++)
            @(posedge clock);
    endtask : wait_cnt

    // Mode fields: parity, 7/8 bits and stop length vary with i
    function automatic logic [7:0] cfg(input int i);
        cfg = {2'b00, i[1:0], ~i[0], i[1], 2'b00};
    endfunction : cfg

    function automatic logic [11:0] mk(input logic [7:0] d,
                                       input logic [7:0] md,
                                       input logic rx);
        logic [11:0] f;
        logic [7:0]  dm;
        int          n;
        n = md[3] ? 8 : 7;
        dm = md[3] ? d : {1'b0, d[6:0]};
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int i = 0; i < n; i++)
            f[i + 1] = dm[i];
        if (md[5:4] != 2'h0 && !(rx && md[5:4] == 2'h1))
            f[n + 1] = (md[5:4] == 2'h1) ? 1'b0
                     : (md[5:4] == 2'h2) ? ~^dm : ^dm;
        return f;
    endfunction : mk

    task automatic report_and_stop;
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (90000) @(posedge clock);
        fails++;
        report_and_stop();
    end

    initial
    begin
        {clock, rst_n, we, re, bit_wr, ext_clk, cyc, rx_n, tx_n} = '0;
        {addr, bit_sel, wdata, fails, compares, done_at} = '0;
        port_tx = 1'b1;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        get(aspir_pkg::ADDR_MODE, rv);
        chk(rv, 8'h00);
        get(aspir_pkg::ADDR_DATA, rv);
        chk(rv, 8'hFF);
        get(16'hFFA4, rv);
        chk(rv, 8'h00);
        put(aspir_pkg::ADDR_STATUS, 8'hFF);
        get(aspir_pkg::ADDR_STATUS, rv);
        chk(rv, 8'h00);
        @(posedge clock);
        addr <= aspir_pkg::ADDR_MODE;
        bit_wr <= 1'b1;
        bit_sel <= 3'h3;
        wdata <= 8'h01;
        @(posedge clock);
        bit_wr <= 1'b0;
        get(aspir_pkg::ADDR_MODE, rv);
        chk(rv, 8'h08);
        for (int i = 0; i < 4; i++)
        begin
            m = 8'h80 | cfg(i);
            put(aspir_pkg::ADDR_BAUD, (i == 3) ? 8'h00 : 8'h10);
            put(aspir_pkg::ADDR_MODE, m);
            t0 = cyc;
            put(aspir_pkg::ADDR_DATA, DAT[i]);
            aspir_remote_i.recv(fr);
            chk(fr, mk(DAT[i], m, 1'b0));
            wait_cnt(tx_n, i + 1);
            chk(tx_n, i + 1);
            chk((done_at - t0 + BIT / 2) / BIT,
                2 + m[3] + (m[5:4] != 0) + m[2] + 7);
        end
        put(aspir_pkg::ADDR_BAUD, 8'h10);
        for (int i = 0; i < 4; i++)
        begin
            m = ((i == 3) ? 8'hC0 : 8'h40) | cfg(i);
            put(aspir_pkg::ADDR_MODE, m);
            t0 = rx_n;
            fx = mk(DAT[i], m, 1'b1);
            if (i == 3)
                fork
                    aspir_remote_i.send(fx);
                    begin
                        put(aspir_pkg::ADDR_DATA, DAT[0]);
                        aspir_remote_i.recv(fr);
                    end
                join
            else
                aspir_remote_i.send(fx);
            chk(rx_n, t0 + 1);
            get(aspir_pkg::ADDR_DATA, rv);
            chk(rv, DAT[i] & (m[3] ? 8'hFF : 8'h7F));
            get(aspir_pkg::ADDR_STATUS, rv);
            chk(rv, 8'h00);
        end
        chk(fr, mk(DAT[0], m, 1'b0));
        m = 8'h68;
        fx = mk(8'h3C, m, 1'b1);
        fx[9] = ~fx[9];
        for (int i = 0; i < 2; i++)
        begin
            put(aspir_pkg::ADDR_MODE, m | ((i == 1) ? 8'h02 : 8'h00));
            t0 = rx_n;
            aspir_remote_i.send(fx);
            chk(rx_n, t0 + 1 - i);
            get(aspir_pkg::ADDR_STATUS, rv);
            chk(rv, 8'h04);
            get(aspir_pkg::ADDR_DATA, rv);
        end
        put(aspir_pkg::ADDR_MODE, m);
        t0 = rx_n;
        aspir_remote_i.send(mk(8'h11, m, 1'b1));
        fx = mk(8'h22, m, 1'b1);
        fx[10] = 1'b0;
        aspir_remote_i.send(fx);
        chk(rx_n, t0 + 2);
        get(aspir_pkg::ADDR_STATUS, rv);
        chk(rv, 8'h03);
        get(aspir_pkg::ADDR_DATA, rv);
        chk(rv, 8'h22);
        put(aspir_pkg::ADDR_MODE, 8'h00);
        t0 = tx_n;
        put(aspir_pkg::ADDR_DATA, 8'h5A);
        @(posedge clock);
        port_tx <= 1'b0;
        repeat (700) @(posedge clock);
        #1;
        chk(txd, 1'b0);
        chk(out_en, 1'b0);
        chk(tx_n, t0);
        report_and_stop();
    end
endmodule : tb
